// ---- shared/tpc_map.svh ----
`ifndef TPC_MAP_SVH
`define TPC_MAP_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define TPC_OFF_PERIOD 8'h00
`define TPC_OFF_DEAD 8'h04
`define TPC_OFF_PDEL 8'h08
`define TPC_OFF_DUTY_A 8'h0c
`define TPC_OFF_DUTY_B 8'h10
`define TPC_OFF_DUTY_C 8'h14
`define TPC_OFF_SEG 8'h18
`define TPC_OFF_GATE 8'h1c
`define TPC_OFF_MODE 8'h20
`define TPC_OFF_SYNCW 8'h24
`define TPC_OFF_SWTRIP 8'h28
`define TPC_OFF_STATUS 8'h2c
// ----------------------------------------
// reset values
// ----------------------------------------
`define TPC_RST_PERIOD 16'h0100
`define TPC_RST_SYNCW 8'h27
`define TPC_RST_SEG 9'h03f
// ----------------------------------------
// field positions
// ----------------------------------------
`define TPC_MODE_DOUBLE 6
`define TPC_SEG_XOVER 6
`define TPC_GATE_HI 8
`define TPC_GATE_LO 9
`define TPC_ST_TRIP 0
`define TPC_ST_SHUT 1
`define TPC_ST_HALF 3
// ----------------------------------------
// bus answers
// ----------------------------------------
`define TPC_RESP_OK 2'b00
`define TPC_RESP_ERR 2'b10
`endif

// ---- shared/tpc_pkg.sv ----
package tpc_pkg;
   // which half of the switching period the timer is in
   typedef enum logic {
      TPC_FIRST_HALF,
      TPC_SECOND_HALF
   } tpc_half_t;
endpackage

// ---- rtl/tpc_phase.sv ----
`timescale 1ns/1ns
module tpc_phase (
   input wire logic [15:0] half_len,
   input wire logic [15:0] pos,
   input wire logic [15:0] duty,
   input wire logic [9:0] dead,
   input wire logic [15:0] min_width,
   output logic hi,
   output logic lo
);
   logic [18:0] edge_pt;
   logic [18:0] hi_w;
   logic [18:0] lo_w;
   logic [18:0] dt;
   logic [18:0] p;
   // ----------------------------------------
   // center based compare with dead time
   // ----------------------------------------
   always_comb begin
      dt = {9'h000, dead};
      p = {3'h0, pos};
      // duty above the half period saturates to full on
      if (duty >= half_len) begin
         edge_pt = 19'h00000;
      end else begin
         edge_pt = {3'h0, half_len} - {3'h0, duty};
      end
      hi_w = {3'h0, half_len} - edge_pt - dt;
      lo_w = edge_pt - dt;
      hi = (p >= edge_pt + dt) && !hi_w[18];
      lo = (p + dt < edge_pt) && !lo_w[18];
      if (hi_w[18] || hi_w < {3'h0, min_width}) begin
         hi = 1'b0;
      end
      if (lo_w[18] || lo_w < {3'h0, min_width}) begin
         lo = 1'b0;
      end
   end
endmodule

// ---- rtl/tpc_top.sv ----
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "tpc_map.svh"
module tpc_top (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic trip_input_n,
   input wire logic analog_trip,
   output logic phase_a_high,
   output logic phase_a_low,
   output logic phase_b_high,
   output logic phase_b_low,
   output logic phase_c_high,
   output logic phase_c_low,
   output logic period_sync_pulse,
   output logic sync_irq,
   output logic shutdown_irq
);
   // ----------------------------------------
   // software registers
   // ----------------------------------------
   logic [15:0] period_reg;
   logic [9:0] dead_time_reg;
   logic [15:0] pulse_deletion_reg;
   logic [15:0] duty_phase_a_reg;
   logic [15:0] duty_phase_b_reg;
   logic [15:0] duty_phase_c_reg;
   logic [8:0] output_segment_reg;
   logic [9:0] gate_chop_reg;
   logic [15:0] mode_control_reg;
   logic [7:0] sync_width_reg;
   // ----------------------------------------
   // shadows, timer and status
   // ----------------------------------------
   logic [15:0] tm_s;
   logic [9:0] dt_s;
   logic [15:0] pd_s;
   logic [15:0] duty_s [3];
   logic [8:0] seg_s;
   logic [15:0] cnt;
   tpc_pkg::tpc_half_t half;
   logic [15:0] pos;
   logic [15:0] last;
   logic load;
   logic [7:0] sync_cnt;
   logic trip_q;
   logic shut;
   logic shut_set;
   logic shut_clr;
   logic sw_trip_wr;
   logic [7:0] chop_div;
   logic chop;
   logic [2:0] raw_hi;
   logic [2:0] raw_lo;
   logic [5:0] next_out;
   logic [5:0] out_q;
   logic out_clr_n;
   // ----------------------------------------
   // bus slave state
   // ----------------------------------------
   logic aw_got;
   logic w_got;
   logic [7:0] waddr;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic wr_go;
   logic [31:0] wval;

   function automatic logic hit(input logic [7:0] a);
      case (a)
         `TPC_OFF_PERIOD, `TPC_OFF_DEAD, `TPC_OFF_PDEL,
         `TPC_OFF_DUTY_A, `TPC_OFF_DUTY_B, `TPC_OFF_DUTY_C,
         `TPC_OFF_SEG, `TPC_OFF_GATE, `TPC_OFF_MODE,
         `TPC_OFF_SYNCW, `TPC_OFF_SWTRIP,
         `TPC_OFF_STATUS: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   endfunction

   function automatic logic [31:0] rd_val(input logic [7:0] a);
      logic [31:0] st;
      st = 32'h00000000;
      st[`TPC_ST_TRIP] = trip_q;
      st[`TPC_ST_SHUT] = shut;
      st[`TPC_ST_HALF] = (half == tpc_pkg::TPC_SECOND_HALF);
      case (a)
         `TPC_OFF_PERIOD: rd_val = {16'h0000, period_reg};
         `TPC_OFF_DEAD: rd_val = {22'h000000, dead_time_reg};
         `TPC_OFF_PDEL: rd_val = {16'h0000, pulse_deletion_reg};
         `TPC_OFF_DUTY_A: rd_val = {16'h0000, duty_phase_a_reg};
         `TPC_OFF_DUTY_B: rd_val = {16'h0000, duty_phase_b_reg};
         `TPC_OFF_DUTY_C: rd_val = {16'h0000, duty_phase_c_reg};
         `TPC_OFF_SEG: rd_val = {23'h000000, output_segment_reg};
         `TPC_OFF_GATE: rd_val = {22'h000000, gate_chop_reg};
         `TPC_OFF_MODE: rd_val = {16'h0000, mode_control_reg};
         `TPC_OFF_SYNCW: rd_val = {24'h000000, sync_width_reg};
         `TPC_OFF_STATUS: rd_val = st;
         default: rd_val = 32'h00000000;
      endcase
   endfunction

   // byte lanes not strobed keep their old contents
   function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
      for (int i = 0; i < 4; i++) begin
         merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction

   // ----------------------------------------
   // write channel
   // ----------------------------------------
   assign wr_go = aw_got && w_got && !s_axi_bvalid;
   // a process rather than an assign, so register changes re-run the merge
   always_comb begin
      wval = merge(rd_val(waddr), wdata_q, wstrb_q);
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         waddr <= 8'h00;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TPC_RESP_OK;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            waddr <= s_axi_awaddr;
            aw_got <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            w_got <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= hit(waddr) ? `TPC_RESP_OK : `TPC_RESP_ERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // read channel
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `TPC_RESP_OK;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val(s_axi_araddr);
            s_axi_rresp <= hit(s_axi_araddr) ? `TPC_RESP_OK
                                              : `TPC_RESP_ERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // register file
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         period_reg <= `TPC_RST_PERIOD;
         dead_time_reg <= 10'h000;
         pulse_deletion_reg <= 16'h0000;
         duty_phase_a_reg <= 16'h0000;
         duty_phase_b_reg <= 16'h0000;
         duty_phase_c_reg <= 16'h0000;
         output_segment_reg <= `TPC_RST_SEG;
         gate_chop_reg <= 10'h000;
         mode_control_reg <= 16'h0000;
         sync_width_reg <= `TPC_RST_SYNCW;
      end else if (wr_go) begin
         case (waddr)
            `TPC_OFF_PERIOD: period_reg <= wval[15:0];
            `TPC_OFF_DEAD: dead_time_reg <= wval[9:0];
            `TPC_OFF_PDEL: pulse_deletion_reg <= wval[15:0];
            `TPC_OFF_DUTY_A: duty_phase_a_reg <= wval[15:0];
            `TPC_OFF_DUTY_B: duty_phase_b_reg <= wval[15:0];
            `TPC_OFF_DUTY_C: duty_phase_c_reg <= wval[15:0];
            `TPC_OFF_SEG: output_segment_reg <= wval[8:0];
            `TPC_OFF_GATE: gate_chop_reg <= wval[9:0];
            `TPC_OFF_MODE: mode_control_reg <= wval[15:0];
            `TPC_OFF_SYNCW: sync_width_reg <= wval[7:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // shutdown controller
   // ----------------------------------------
   // software trip write
   assign sw_trip_wr = wr_go && (waddr == `TPC_OFF_SWTRIP);
   assign shut_clr = wr_go && (waddr == `TPC_OFF_STATUS) &&
                     wval[`TPC_ST_SHUT];
   assign shut_set = !trip_q || analog_trip || sw_trip_wr;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         trip_q <= 1'b1;
         shut <= 1'b0;
         shutdown_irq <= 1'b0;
      end else begin
         trip_q <= trip_input_n;
         // a new cause in the clearing cycle keeps the latch set
         if (shut_set) begin
            shut <= 1'b1;
         end else if (shut_clr) begin
            shut <= 1'b0;
         end
         shutdown_irq <= shut_set && !shut;
      end
   end

   // ----------------------------------------
   // three phase timing unit
   // ----------------------------------------
   assign last = (tm_s == 16'h0000) ? 16'h0000 : tm_s - 16'h0001;
   assign pos = (half == tpc_pkg::TPC_SECOND_HALF) ? last - cnt : cnt;
   assign load = !shut && (cnt == 16'h0000) &&
                 ((half == tpc_pkg::TPC_FIRST_HALF) ||
                  mode_control_reg[`TPC_MODE_DOUBLE]);

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt <= 16'h0000;
         half <= tpc_pkg::TPC_FIRST_HALF;
      end else if (shut) begin
         cnt <= 16'h0000;
         half <= tpc_pkg::TPC_FIRST_HALF;
      end else if (cnt >= last) begin
         cnt <= 16'h0000;
         half <= (half == tpc_pkg::TPC_FIRST_HALF) ?
                 tpc_pkg::TPC_SECOND_HALF : tpc_pkg::TPC_FIRST_HALF;
      end else begin
         cnt <= cnt + 16'h0001;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         tm_s <= `TPC_RST_PERIOD;
         dt_s <= 10'h000;
         pd_s <= 16'h0000;
         duty_s[0] <= 16'h0000;
         duty_s[1] <= 16'h0000;
         duty_s[2] <= 16'h0000;
         seg_s <= `TPC_RST_SEG;
      end else if (load) begin
         tm_s <= period_reg;
         dt_s <= dead_time_reg;
         pd_s <= pulse_deletion_reg;
         duty_s[0] <= duty_phase_a_reg;
         duty_s[1] <= duty_phase_b_reg;
         duty_s[2] <= duty_phase_c_reg;
         seg_s <= output_segment_reg;
      end
   end

   for (genvar g = 0; g < 3; g++) begin : g_phase
      tpc_phase u_phase (
         .half_len(tm_s),
         .pos(pos),
         .duty(duty_s[g]),
         .dead(dt_s),
         .min_width(pd_s),
         .hi(raw_hi[g]),
         .lo(raw_lo[g])
      );
   end

   // ----------------------------------------
   // sync pulse
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sync_cnt <= 8'h00;
         period_sync_pulse <= 1'b0;
         sync_irq <= 1'b0;
      end else begin
         sync_irq <= load;
         if (load) begin
            sync_cnt <= sync_width_reg;
            period_sync_pulse <= 1'b1;
         end else if (sync_cnt != 8'h00) begin
            sync_cnt <= sync_cnt - 8'h01;
         end else begin
            period_sync_pulse <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // gate drive chopping
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         chop_div <= 8'h00;
         chop <= 1'b0;
      end else if (chop_div >= gate_chop_reg[7:0]) begin
         chop_div <= 8'h00;
         chop <= !chop;
      end else begin
         chop_div <= chop_div + 8'h01;
      end
   end

   // ----------------------------------------
   // output control unit
   // ----------------------------------------
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         if (seg_s[`TPC_SEG_XOVER + i]) begin
            next_out[2*i] = raw_lo[i];
            next_out[2*i+1] = raw_hi[i];
         end else begin
            next_out[2*i] = raw_hi[i];
            next_out[2*i+1] = raw_lo[i];
         end
         next_out[2*i] = next_out[2*i] && seg_s[2*i];
         next_out[2*i+1] = next_out[2*i+1] && seg_s[2*i+1];
         // separate high and low chop enables
         if (gate_chop_reg[`TPC_GATE_HI]) begin
            next_out[2*i] = next_out[2*i] && chop;
         end
         if (gate_chop_reg[`TPC_GATE_LO]) begin
            next_out[2*i+1] = next_out[2*i+1] && chop;
         end
      end
   end

   // trip pin clears outputs with no clock edge
   assign out_clr_n = arst_n && trip_input_n;

   always_ff @(posedge core_clk or negedge out_clr_n) begin
      if (!out_clr_n) begin
         out_q <= 6'h00;
      end else if (shut) begin
         out_q <= 6'h00;
      end else begin
         out_q <= next_out;
      end
   end

   assign phase_a_high = out_q[0];
   assign phase_a_low = out_q[1];
   assign phase_b_high = out_q[2];
   assign phase_b_low = out_q[3];
   assign phase_c_high = out_q[4];
   assign phase_c_low = out_q[5];
endmodule

// ---- tb/tpc_properties.sv ----
`timescale 1ns/1ns
module tpc_properties (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic trip_input_n,
   input wire logic phase_a_high,
   input wire logic phase_a_low,
   input wire logic phase_b_high,
   input wire logic phase_b_low,
   input wire logic phase_c_high,
   input wire logic phase_c_low,
   input wire logic period_sync_pulse,
   input wire logic sync_irq,
   input wire logic shutdown_irq
);
   logic any_on;
   assign any_on = phase_a_high | phase_a_low | phase_b_high | phase_b_low
      | phase_c_high | phase_c_low;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   // ----------------------------------------
   // sequences
   // ----------------------------------------
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence shut_seq;
      shutdown_irq ##1 !shutdown_irq;
   endsequence
   sequence sync_rise;
      $rose(period_sync_pulse);
   endsequence
   // ----------------------------------------
   // properties
   // ----------------------------------------
   AST_TRIP_OFF: assert property (!trip_input_n |-> !any_on)
      else $error("gate output on while trip pin low");
   AST_SHUT_OFF: assert property (shut_seq |-> !any_on)
      else $error("gate output on after shutdown");
   AST_SYNC_IRQ: assert property (sync_rise |-> ##[0:1] sync_irq)
      else $error("no sync interrupt at sync pulse");
   // a leg with both switches on shorts the supply
   AST_NO_SHOOT: assert property (!(phase_a_high && phase_a_low) &&
      !(phase_b_high && phase_b_low) && !(phase_c_high && phase_c_low))
      else $error("both switches of a leg on");
   AST_WR_RESP: assert property (wr_taken |=> !s_axi_awready ##1 s_axi_bvalid)
      else $error("write response missing");
   AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid && !s_axi_arready)
      else $error("read response missing");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
endmodule
bind tpc_top tpc_properties u_chk (.core_clk, .arst_n, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
   .s_axi_rready, .trip_input_n, .phase_a_high, .phase_a_low, .phase_b_high,
   .phase_b_low, .phase_c_high, .phase_c_low, .period_sync_pulse, .sync_irq,
   .shutdown_irq);

// ---- tb/tpc_gate_drive.sv ----
`timescale 1ns/1ns
module tpc_gate_drive (
   input wire logic core_clk,
   input wire logic fault,
   input wire logic [5:0] gates,
   output logic trip_input_n,
   output int shoot_cnt
);
   // ----------------------------------------
   // inverter fault and leg monitor
   // ----------------------------------------
   // fault pulls trip low
   assign trip_input_n = !fault;
   initial shoot_cnt = 0;
   always @(posedge core_clk) begin
      if (&gates[5:4] || &gates[3:2] || &gates[1:0]) begin
         shoot_cnt <= shoot_cnt + 1;
      end
   end
endmodule

// ---- tb/tpc_top_tb.sv ----
`timescale 1ns/1ns
`include "tpc_map.svh"
module tpc_top_tb;
   logic core_clk = 1'b0, arst_n = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, analog_trip = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, trip_input_n, fault = 1'b0;
   logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
   logic [5:0] outs;
   logic period_sync_pulse, sync_irq, shutdown_irq;
   logic [31:0] d, s1;
   int error_cnt = 0, checks_done = 0, cyc_cnt = 0, shut_cnt = 0;
   int shoot_cnt, w, g, n_hi, n_lo;
   // ends on the reset pattern, which the chop and restore checks rely on
   logic [8:0] seg_tab [4] = '{9'h17f, 9'h0bf, 9'h036, 9'h03f};
   logic [5:0] out_tab [4] = '{6'h15, 6'h2a, 6'h02, 6'h26};
   always #5 core_clk = ~core_clk;
   tpc_top dut (.core_clk, .arst_n, .s_axi_awaddr, .s_axi_awprot(3'h0),
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trip_input_n,
      .analog_trip, .phase_a_high(outs[5]), .phase_a_low(outs[4]),
      .phase_b_high(outs[3]), .phase_b_low(outs[2]), .phase_c_high(outs[1]),
      .phase_c_low(outs[0]), .period_sync_pulse, .sync_irq, .shutdown_irq);
   tpc_gate_drive u_inv (.core_clk, .fault, .gates(outs), .trip_input_n,
      .shoot_cnt);
   always @(posedge core_clk) begin
      if (shutdown_irq === 1'b1) shut_cnt++;
      cyc_cnt++;
      // long enough for every test with margin; a hang ends here
      if (cyc_cnt == 20000) begin
         error_cnt++;
         end_sim();
      end
   end
   task automatic end_sim;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, e);
      checks_done++;
      if (s !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // bready only after bvalid, so a stalled response is seen too
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      @(posedge core_clk);
      while (s_axi_awvalid || s_axi_wvalid) begin
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         @(posedge core_clk);
      end
      while (s_axi_bvalid !== 1'b1) @(posedge core_clk);
      s_axi_bready <= 1'b1;
      @(posedge core_clk);
      last_resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      @(posedge core_clk);
      while (s_axi_arready !== 1'b1) @(posedge core_clk);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge core_clk);
      s_axi_rready <= 1'b1;
      @(posedge core_clk);
      v = s_axi_rdata;
      last_resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic sync_meas(output int wd, gp);
      wd = 0;
      gp = 0;
      // start from a low level so a pulse under way is not cut short
      while (period_sync_pulse !== 1'b0) @(posedge core_clk);
      while (period_sync_pulse !== 1'b1) @(posedge core_clk);
      while (period_sync_pulse === 1'b1) begin
         wd++;
         gp++;
         @(posedge core_clk);
      end
      while (period_sync_pulse !== 1'b1) begin
         gp++;
         @(posedge core_clk);
      end
   endtask
   task automatic clear_shut;
      wr(`TPC_OFF_STATUS, 32'h2);
      cyc(84);
      chk("restored", {26'h0, outs}, 32'h26);
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      cyc(5);
      arst_n <= 1'b1;
      rd(`TPC_OFF_PERIOD, d); chk("period rst", d, 32'h100);
      rd(`TPC_OFF_SYNCW, d); chk("syncw rst", d, 32'h27);
      rd(`TPC_OFF_SEG, d); chk("seg rst", d, 32'h3f);
      rd(`TPC_OFF_MODE, d); chk("mode rst", d[6], 32'h0);
      rd(`TPC_OFF_STATUS, d); chk("trip lvl", d[0], 32'h1);
      rd(8'h30, d); chk("unmapped rd", d, 32'h0);
      chk("unmapped rresp", last_resp, `TPC_RESP_ERR);
      wr(8'h30, 32'h5); chk("unmapped bresp", last_resp, `TPC_RESP_ERR);
      wr(`TPC_OFF_DEAD, 32'h3ff); chk("wr bresp", last_resp, `TPC_RESP_OK);
      rd(`TPC_OFF_DEAD, d); chk("dead", d, 32'h3ff);
      wr(`TPC_OFF_DEAD, 32'h0);
      wr(`TPC_OFF_PDEL, 32'h0);
      wr(`TPC_OFF_PERIOD, 32'd20);
      wr(`TPC_OFF_DUTY_A, 32'd20);
      wr(`TPC_OFF_DUTY_B, 32'd0);
      wr(`TPC_OFF_DUTY_C, 32'd20);
      wr(`TPC_OFF_SYNCW, 32'h3);
      // the reset period of 512 cycles must end before new values load
      cyc(600);
      chk("duty pattern", {26'h0, outs}, 32'h26);
      sync_meas(w, g);
      chk("sync width", w, 32'd4);
      chk("single gap", g, 32'd40);
      wr(`TPC_OFF_MODE, 32'h40);
      cyc(84);
      sync_meas(w, g);
      chk("double gap", g, 32'd20);
      g = 0;
      repeat (40) begin
         @(posedge core_clk);
         g += sync_irq;
      end
      chk("sync irq", g, 32'd2);
      rd(`TPC_OFF_STATUS, s1);
      // samples exactly 20 cycles apart fall in neighbouring halves
      cyc(17);
      rd(`TPC_OFF_STATUS, d);
      chk("half flag", s1[3] ^ d[3], 32'h1);
      for (int i = 0; i < 4; i++) begin
         wr(`TPC_OFF_SEG, {23'h0, seg_tab[i]});
         cyc(44);
         chk("segment", {26'h0, outs}, {26'h0, out_tab[i]});
      end
      for (int i = 0; i < 2; i++) begin
         wr(`TPC_OFF_GATE, i ? 32'h201 : 32'h100);
         cyc(44);
         n_hi = 0;
         n_lo = 0;
         repeat (8) begin
            @(posedge core_clk);
            n_hi += outs[5];
            n_lo += outs[2];
         end
         chk("chop high", n_hi, i ? 32'd8 : 32'd4);
         chk("chop low", n_lo, i ? 32'd4 : 32'd8);
      end
      wr(`TPC_OFF_GATE, 32'h0);
      w = shut_cnt;
      wr(`TPC_OFF_SWTRIP, 32'h1);
      cyc(3);
      chk("sw trip outs", {26'h0, outs}, 32'h0);
      chk("sw trip irq", shut_cnt - w, 32'd1);
      rd(`TPC_OFF_STATUS, d); chk("shut flag", d[1], 32'h1);
      g = 0;
      repeat (50) begin
         @(posedge core_clk);
         g += period_sync_pulse;
      end
      chk("no sync in shutdown", g, 32'd0);
      clear_shut();
      w = shut_cnt;
      analog_trip <= 1'b1;
      cyc(1);
      analog_trip <= 1'b0;
      cyc(3);
      chk("analog trip outs", {26'h0, outs}, 32'h0);
      chk("analog trip irq", shut_cnt - w, 32'd1);
      clear_shut();
      @(negedge core_clk);
      fault = 1'b1;
      #1;
      chk("pin trip outs", {26'h0, outs}, 32'h0);
      @(posedge core_clk);
      rd(`TPC_OFF_STATUS, d); chk("pin level", d[0], 32'h0);
      fault <= 1'b0;
      cyc(2);
      clear_shut();
      chk("leg short", shoot_cnt, 32'd0);
      end_sim();
   end
endmodule
